// File: rtl/eeprom_slave.sv
// two-wire serial eeprom slave: 1024 bytes, byte and page write, timed programming
// assumes an open-drain bus resolved outside; scl is also the link clock
//
// Contract
// - acknowledger holds data low through ninth high
// - on master nack memory releases data line
// - address lsb one reads, zero writes
// - write protect high guards upper 512 bytes
// - protected writes: ack addresses, nack data
// - write carries acknowledged eight-bit word address
// - byte mode: first byte plus six more
// - programming starts at stop, 10 ms/byte
// - busy device ignores bus, never acknowledges
// - page write: eight acked bytes, 31.5 ms
// - page write increments only low three bits
// - ninth page byte nacked, transfer discarded
// - current, random and sequential reads supported
// - low eight bits wrap, page bits fixed
// - address: type code, chip select, page bits
// - reads continue while master keeps acknowledging
module eeprom_slave #(
  parameter logic [23:0] BYTE_CYC = 24'(eeprom_pkg::BYTE_CYC),
  parameter logic [23:0] PAGE_CYC = 24'(eeprom_pkg::PAGE_CYC)
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic write_protect_in,
  input wire logic chip_select_pin_in,
  input wire logic page_mode_in,
  output logic write_busy_out
);
  // link domain: sda is stable while scl is high, so sample it there
  logic bit_ff;
  logic tgl_ff;
  logic nxt_bit;
  logic nxt_tgl;

  always_comb begin
    nxt_bit = sda_in;
    nxt_tgl = ~tgl_ff;
  end

  always_ff @(posedge scl_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_ff <= 1'b0;
      tgl_ff <= 1'b0;
    end else begin
      bit_ff <= nxt_bit;
      tgl_ff <= nxt_tgl;
    end
  end

  logic [eeprom_pkg::SYNC_W-1:0] sync_q;
  logic tgl_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;
  logic cs_s;

  sync2 #(.W(eeprom_pkg::SYNC_W)) u_sync (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .d_in({tgl_ff, scl_in, sda_in, write_protect_in, chip_select_pin_in}),
    .q_out(sync_q)
  );
  assign {tgl_s, scl_s, sda_s, wp_s, cs_s} = sync_q;

  logic tgl_d_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      // match the synchroniser's reset level so no false edge follows reset
      tgl_d_ff <= 1'b0;
      scl_d_ff <= 1'b0;
      sda_d_ff <= 1'b0;
    end else begin
      tgl_d_ff <= tgl_s;
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // bit_ff is read only after its toggle has crossed, so it is settled
  assign rise_ev = tgl_s ^ tgl_d_ff;
  assign fall_ev = scl_d_ff & ~scl_s;
  assign start_ev = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_ev = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  eeprom_pkg::link_state_e state_ff;
  eeprom_pkg::link_state_e nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic ack_ff;
  logic nxt_ack;
  logic [7:0] shreg_ff;
  logic [7:0] nxt_shreg;
  logic [eeprom_pkg::ADDR_W-1:0] addr_ff;
  logic [eeprom_pkg::ADDR_W-1:0] nxt_addr;
  logic oe_ff;
  logic nxt_oe;
  logic mack_ff;
  logic nxt_mack;
  logic [3:0] wcnt_ff;
  logic [3:0] nxt_wcnt;
  logic over_ff;
  logic nxt_over;
  logic prot_ff;
  logic nxt_prot;
  logic pmode_ff;
  logic nxt_pmode;
  logic busy_ff;
  logic nxt_busy;
  logic [23:0] tmr_ff;
  logic [23:0] nxt_tmr;
  logic [3:0] left_ff;
  logic [3:0] nxt_left;
  logic commit;
  logic dev_match;
  logic [3:0] limit;
  logic [7:0] rd_byte;
  logic [eeprom_pkg::ADDR_W-1:0] buf_a_ff [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::ADDR_W-1:0] nxt_buf_a [eeprom_pkg::PAGE_BYTES];
  logic [7:0] buf_d_ff [eeprom_pkg::PAGE_BYTES];
  logic [7:0] nxt_buf_d [eeprom_pkg::PAGE_BYTES];
  logic [7:0] mem [eeprom_pkg::MEM_DEPTH];

  assign rd_byte = mem[addr_ff];
  assign limit = pmode_ff ? eeprom_pkg::PAGE_MODE_MAX : eeprom_pkg::BYTE_MODE_MAX;
  assign dev_match = (shreg_ff[eeprom_pkg::DEV_TYPE_MSB:eeprom_pkg::DEV_TYPE_LSB]
                      == eeprom_pkg::DEV_TYPE) && (shreg_ff[eeprom_pkg::DEV_CS_BIT] == cs_s)
                     && !busy_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_ack = ack_ff;
    nxt_shreg = shreg_ff;
    nxt_addr = addr_ff;
    nxt_oe = oe_ff;
    nxt_mack = mack_ff;
    nxt_wcnt = wcnt_ff;
    nxt_over = over_ff;
    nxt_prot = prot_ff;
    nxt_pmode = pmode_ff;
    nxt_busy = busy_ff;
    nxt_tmr = tmr_ff;
    nxt_left = left_ff;
    nxt_buf_a = buf_a_ff;
    nxt_buf_d = buf_d_ff;
    commit = 1'b0;
    // programming timer; the buffer is written to the array at the end
    if (busy_ff) begin
      if (tmr_ff == 24'h000000) begin
        if (left_ff <= 4'h1) begin
          nxt_busy = 1'b0;
          commit = 1'b1;
        end else begin
          nxt_left = left_ff - 4'h1;
          nxt_tmr = BYTE_CYC - 24'h000001;
        end
      end else begin
        nxt_tmr = tmr_ff - 24'h000001;
      end
    end
    if (start_ev) begin
      nxt_state = eeprom_pkg::ST_DEV;
      nxt_cnt = 4'h0;
      nxt_ack = 1'b0;
      nxt_oe = 1'b0;
    end else if (stop_ev) begin
      if (state_ff == eeprom_pkg::ST_WDATA && wcnt_ff != 4'h0 && !over_ff && !prot_ff) begin
        nxt_busy = 1'b1;
        nxt_tmr = (pmode_ff ? PAGE_CYC : BYTE_CYC) - 24'h000001;
        nxt_left = pmode_ff ? 4'h1 : wcnt_ff;
      end
      nxt_state = eeprom_pkg::ST_IDLE;
      nxt_ack = 1'b0;
      nxt_oe = 1'b0;
    end else if (state_ff != eeprom_pkg::ST_IDLE && state_ff != eeprom_pkg::ST_IGNORE) begin
      if (rise_ev) begin
        if (ack_ff) begin
          if (state_ff == eeprom_pkg::ST_RDATA) begin
            nxt_mack = ~bit_ff;
          end
        end else if (cnt_ff < eeprom_pkg::BITS_PER_BYTE) begin
          if (state_ff != eeprom_pkg::ST_RDATA) begin
            nxt_shreg = {shreg_ff[6:0], bit_ff};
          end
          nxt_cnt = cnt_ff + 4'h1;
        end
      end else if (fall_ev) begin
        if (ack_ff) begin
          // end of the ninth clock: release, or start the next read byte
          nxt_ack = 1'b0;
          nxt_cnt = 4'h0;
          nxt_oe = 1'b0;
          if (state_ff == eeprom_pkg::ST_RDATA) begin
            if (mack_ff) begin
              nxt_shreg = rd_byte;
              nxt_oe = ~rd_byte[7];
            end else begin
              nxt_state = eeprom_pkg::ST_IGNORE;
            end
          end
        end else if (cnt_ff == eeprom_pkg::BITS_PER_BYTE) begin
          nxt_ack = 1'b1;
          nxt_oe = 1'b0;
          case (state_ff)
            eeprom_pkg::ST_DEV: begin
              if (dev_match) begin
                nxt_oe = 1'b1;
                nxt_addr[9:8] = shreg_ff[eeprom_pkg::DEV_PAGE_MSB:eeprom_pkg::DEV_PAGE_LSB];
                if (shreg_ff[eeprom_pkg::DEV_RW_BIT]) begin
                  nxt_state = eeprom_pkg::ST_RDATA;
                  nxt_mack = 1'b1;
                end else begin
                  nxt_state = eeprom_pkg::ST_WORD;
                end
              end else begin
                nxt_state = eeprom_pkg::ST_IGNORE;
                nxt_ack = 1'b0;
              end
            end
            eeprom_pkg::ST_WORD: begin
              nxt_oe = 1'b1;
              nxt_addr[7:0] = shreg_ff;
              nxt_state = eeprom_pkg::ST_WDATA;
              nxt_wcnt = 4'h0;
              nxt_over = 1'b0;
              nxt_prot = wp_s & addr_ff[9];
              nxt_pmode = page_mode_in;
            end
            eeprom_pkg::ST_WDATA: begin
              if (wcnt_ff >= limit) begin
                nxt_over = 1'b1;
              end else if (!prot_ff) begin
                nxt_oe = 1'b1;
                nxt_buf_a[wcnt_ff[2:0]] = addr_ff;
                nxt_buf_d[wcnt_ff[2:0]] = shreg_ff;
                nxt_wcnt = wcnt_ff + 4'h1;
                if (pmode_ff) begin
                  nxt_addr[2:0] = addr_ff[2:0] + 3'h1;
                end else begin
                  nxt_addr[7:0] = addr_ff[7:0] + 8'h01;
                end
              end
            end
            eeprom_pkg::ST_RDATA: begin
              nxt_addr[7:0] = addr_ff[7:0] + 8'h01;
            end
            default: begin
              nxt_ack = 1'b0;
            end
          endcase
        end else if (state_ff == eeprom_pkg::ST_RDATA) begin
          nxt_oe = ~shreg_ff[3'(4'h7 - cnt_ff)];
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= eeprom_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      shreg_ff <= 8'h00;
      addr_ff <= 10'h000;
      oe_ff <= 1'b0;
      mack_ff <= 1'b0;
      wcnt_ff <= 4'h0;
      over_ff <= 1'b0;
      prot_ff <= 1'b0;
      pmode_ff <= 1'b0;
      busy_ff <= 1'b0;
      tmr_ff <= 24'h000000;
      left_ff <= 4'h0;
      for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
        buf_a_ff[i] <= 10'h000;
        buf_d_ff[i] <= 8'h00;
      end
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      ack_ff <= nxt_ack;
      shreg_ff <= nxt_shreg;
      addr_ff <= nxt_addr;
      oe_ff <= nxt_oe;
      mack_ff <= nxt_mack;
      wcnt_ff <= nxt_wcnt;
      over_ff <= nxt_over;
      prot_ff <= nxt_prot;
      pmode_ff <= nxt_pmode;
      busy_ff <= nxt_busy;
      tmr_ff <= nxt_tmr;
      left_ff <= nxt_left;
      buf_a_ff <= nxt_buf_a;
      buf_d_ff <= nxt_buf_d;
    end
  end

  // array is written only when the timed cycle completes, never mid-cycle
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
      if (commit && 4'(i) < wcnt_ff) begin
        mem[buf_a_ff[i]] <= buf_d_ff[i];
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe_ff;
  assign write_busy_out = busy_ff;

  logic [23:0] ew_len_ff;
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ew_len_ff <= 24'h000000;
    end else begin
      ew_len_ff <= busy_ff ? ew_len_ff + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  sequence s_byte_end;
    fall_ev && cnt_ff == eeprom_pkg::BITS_PER_BYTE && !ack_ff && !start_ev && !stop_ev;
  endsequence

  sequence s_ack_end;
    fall_ev && ack_ff && !start_ev && !stop_ev;
  endsequence

  a_word_ack: assert property (state_ff == eeprom_pkg::ST_WORD ##0 s_byte_end
    |=> oe_ff && ack_ff && state_ff == eeprom_pkg::ST_WDATA)
    else $error("word address not acknowledged");
  // judged at the data byte's end: the word address ack also stands in the data state
  a_prot_nack: assert property (prot_ff && state_ff == eeprom_pkg::ST_WDATA
    ##0 s_byte_end |=> !oe_ff)
    else $error("protected data byte acknowledged");
  a_busy_quiet: assert property (busy_ff |-> !oe_ff)
    else $error("device drove the bus while programming");
  a_read_dir: assert property (state_ff == eeprom_pkg::ST_DEV && dev_match
    && shreg_ff[0] ##0 s_byte_end |=> state_ff == eeprom_pkg::ST_RDATA)
    else $error("read bit did not select read");
  a_page_wrap: assert property (state_ff == eeprom_pkg::ST_WDATA && pmode_ff
    ##0 s_byte_end |=> addr_ff[9:3] == $past(addr_ff[9:3]))
    else $error("page write changed upper address bits");
  a_over_discard: assert property (stop_ev && over_ff && !busy_ff |=> !busy_ff)
    else $error("overrun transfer was programmed");
  a_ew_start: assert property (stop_ev && state_ff == eeprom_pkg::ST_WDATA
    && wcnt_ff != 4'h0 && !over_ff && !prot_ff |=> busy_ff ##1 busy_ff)
    else $error("programming did not start at stop");
  a_ew_page_len: assert property ($fell(busy_ff) && pmode_ff
    |-> $past(ew_len_ff) + 24'h000001 == PAGE_CYC)
    else $error("page programming time wrong");
  a_read_release: assert property (state_ff == eeprom_pkg::ST_RDATA && !mack_ff
    ##0 s_ack_end |=> !oe_ff && state_ff == eeprom_pkg::ST_IGNORE)
    else $error("data line not released after master nack");
  a_read_wrap: assert property (state_ff == eeprom_pkg::ST_RDATA ##0 s_byte_end
    |=> addr_ff[7:0] == $past(addr_ff[7:0]) + 8'h01 && addr_ff[9:8] == $past(addr_ff[9:8]))
    else $error("read pointer did not wrap in page");
endmodule

// File: include/eeprom_pkg.sv
// constants, timing counts and state encoding of the serial eeprom slave
// assumes a 40 MHz system clock; all counts derive from it
package eeprom_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int EW_BYTE_US = 10_000;
  localparam int ERASE_US = 3_500;
  localparam int PAGE_WR_US = 28_000;
  localparam int BYTE_CYC = EW_BYTE_US * CYC_PER_US;
  localparam int PAGE_CYC = (ERASE_US + PAGE_WR_US) * CYC_PER_US;
  localparam int TMR_W = 24;
  localparam int ADDR_W = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int PAGE_BYTES = 8;
  localparam logic [3:0] BYTE_MODE_MAX = 4'h7;
  localparam logic [3:0] PAGE_MODE_MAX = 4'h8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_CS_BIT = 3;
  localparam int DEV_PAGE_MSB = 2;
  localparam int DEV_PAGE_LSB = 1;
  localparam int DEV_RW_BIT = 0;
  localparam int SYNC_W = 5;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WORD,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } link_state_e;
endpackage

// File: rtl/sync2.sv
// two flip-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level or a toggle; no multi-bit words
module sync2 #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_meta = d_in;
    nxt_q = meta_ff;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_ff <= '0;
      q_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      q_ff <= nxt_q;
    end
  end

  assign q_out = q_ff;
endmodule

// File: testbench/bus_master_model.sv
// two-wire bus master model: makes the bus clock and drives the data wire
// assumes an open-drain data wire with a pull-up resolved in the bench
module bus_master_model #(
  parameter int HALF = 10
) (
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  // also a repeated start when entered with the clock low
  task automatic start();
    sda_out <= 1'b1;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_out <= 1'b0;
    hold(HALF);
    scl_out <= 1'b0;
    hold(2);
  endtask
  task automatic stop();
    sda_out <= 1'b0;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    sda_out <= 1'b1;
    hold(HALF);
  endtask
  // data settles in the low phase, stands through the whole high phase
  task automatic bit_io(input logic b, output logic got);
    sda_out <= b;
    hold(HALF);
    scl_out <= 1'b1;
    hold(HALF);
    got = sda_in;
    scl_out <= 1'b0;
    hold(2);
  endtask
  task automatic send(input logic [7:0] b, output logic nak);
    logic d;
    for (int i = 7; i >= 0; i--) bit_io(b[i], d);
    bit_io(1'b1, nak);
  endtask
  // master acks every byte but the last one it wants
  task automatic recv(input logic last, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d);
      b[i] = d;
    end
    bit_io(last, d);
  endtask
endmodule

// File: testbench/eeprom_slave_tb.sv
// self-checking bench for the serial eeprom slave
// assumes the bus master model and a pull-up on the data wire
module eeprom_slave_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BYTE_N = 400;
  localparam int PAGE_N = 500;
  logic clock_in;
  logic nrst = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe;
  logic sda_w;
  logic wp = 1'b0;
  logic cs = 1'b1;
  logic pm = 1'b0;
  logic busy;
  logic nak;
  logic [7:0] rd;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  assign sda_w = sda_m & ~(sda_oe & ~sda_o);
  eeprom_slave #(.BYTE_CYC(24'(BYTE_N)), .PAGE_CYC(24'(PAGE_N))) dut_u (
    .clock_in(clock_in), .nrst_in(nrst), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .write_protect_in(wp),
    .chip_select_pin_in(cs), .page_mode_in(pm), .write_busy_out(busy));
  bus_master_model #(.HALF(10)) mst_u (
    .clock_in(clock_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  // hang guard: some 2.7 times the roughly 14,600 cycles the scenarios need
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] dev(input logic [1:0] pg, input logic rd_dir);
    return {eeprom_pkg::DEV_TYPE, 1'b1, pg, rd_dir};
  endfunction
  task automatic addr_w(input logic [1:0] pg, input logic [7:0] wa);
    mst_u.start();
    mst_u.send(dev(pg, 1'b0), nak);
    chk({7'h0, nak}, 8'h00);
    mst_u.send(wa, nak);
    chk({7'h0, nak}, 8'h00);
  endtask
  task automatic addr_r(input logic [1:0] pg);
    mst_u.start();
    mst_u.send(dev(pg, 1'b1), nak);
    chk({7'h0, nak}, 8'h00);
  endtask
  // slack covers bus time already spent since the stop
  task automatic wait_prog(input int n, input int slack);
    int c;
    c = 0;
    chk({7'h0, busy}, 8'h01);
    while (busy === 1'b1 && c < n + 50) begin
      @(posedge clock_in);
      c++;
    end
    chk({7'h0, c <= n && c >= n - slack}, 8'h01);
  endtask
  task automatic t_bad_addr();
    mst_u.start();
    mst_u.send(8'h52, nak);
    chk({7'h0, nak}, 8'h01);
    mst_u.start();
    mst_u.send(8'hA2, nak);
    chk({7'h0, nak}, 8'h01);
    mst_u.stop();
    // same address byte is taken once the chip-select level matches bit 3
    cs <= 1'b0;
    mst_u.start();
    mst_u.send(8'hA2, nak);
    chk({7'h0, nak}, 8'h00);
    mst_u.stop();
    cs <= 1'b1;
  endtask
  task automatic t_byte_write();
    pm <= 1'b0;
    addr_w(2'h0, 8'hFF);
    mst_u.send(8'h11, nak);
    chk({7'h0, nak}, 8'h00);
    mst_u.send(8'h22, nak);
    chk({7'h0, nak}, 8'h00);
    mst_u.stop();
    mst_u.start();
    mst_u.send(dev(2'h0, 1'b0), nak);
    chk({7'h0, nak}, 8'h01);
    mst_u.stop();
    wait_prog(2 * BYTE_N, 300);
  endtask
  task automatic t_read();
    addr_w(2'h0, 8'hFF);
    addr_r(2'h0);
    mst_u.recv(1'b1, rd);
    chk(rd, 8'h11);
    mst_u.hold(8);
    chk({7'h0, sda_w}, 8'h01);
    mst_u.stop();
    addr_r(2'h0);
    mst_u.recv(1'b1, rd);
    chk(rd, 8'h22);
    mst_u.stop();
  endtask
  task automatic t_page();
    pm <= 1'b1;
    addr_w(2'h1, 8'h3D);
    for (int i = 0; i < 8; i++) begin
      mst_u.send(8'h40 + 8'(i), nak);
      chk({7'h0, nak}, 8'h00);
    end
    mst_u.stop();
    wait_prog(PAGE_N, 20);
    addr_w(2'h1, 8'h38);
    addr_r(2'h1);
    for (int j = 0; j < 8; j++) begin
      mst_u.recv(j == 7, rd);
      chk(rd, 8'h40 + 8'((j + 3) % 8));
    end
    mst_u.stop();
  endtask
  task automatic t_protect();
    wp <= 1'b1;
    pm <= 1'b0;
    addr_w(2'h2, 8'h10);
    mst_u.send(8'h5A, nak);
    chk({7'h0, nak}, 8'h01);
    mst_u.stop();
    chk({7'h0, busy}, 8'h00);
    addr_w(2'h0, 8'h05);
    mst_u.send(8'h77, nak);
    chk({7'h0, nak}, 8'h00);
    mst_u.stop();
    wait_prog(BYTE_N, 20);
    wp <= 1'b0;
  endtask
  // byte mode refuses its 8th byte, page mode its 9th; nothing programmed
  task automatic t_overflow();
    for (int m = 0; m < 2; m++) begin
      pm <= m[0];
      addr_w(2'h0, 8'h40);
      for (int i = 0; i < 8 + m; i++) begin
        mst_u.send(8'h33, nak);
        chk({7'h0, nak}, {7'h0, i == 7 + m});
      end
      mst_u.stop();
      chk({7'h0, busy}, 8'h00);
    end
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    nrst <= 1'b1;
    repeat (4) @(posedge clock_in);
    t_bad_addr();
    t_byte_write();
    t_read();
    t_page();
    t_protect();
    t_overflow();
    test_done();
  end
endmodule
